/* File: climate_alert_core.sv */
/*
 * Mode control, measurement history, alert thresholds and offsets of a
 * temperature/humidity sensor, behind its decoded serial command port.
 * Assumes a serial front end that presents one command strobe per
 * decoded command with its word and checksum, and a measurement engine
 * that presents raw samples with a strobe. The serial clock arrives as
 * a pin and is only sampled here to detect link activity.
 */
`timescale 1ns/100ps
`default_nettype none

`include "climate_alert_params.svh"

module climate_alert_core #(
	parameter int unsigned NVM_CYCLES = `NVM_PROG_CYCLES
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         arst_n,
	// Pins
	input  wire logic                         reset_pin_n,
	input  wire logic                         scl,
	output logic                              alert,
	// Decoded commands
	input  wire logic                         cmd_valid,
	input  wire climate_alert_pkg::command_s  cmd,
	output logic                              cmd_nack,
	output logic                              cmd_ack,
	// Raw measurements and soft reset request
	input  wire logic                         sample_valid,
	input  wire climate_alert_pkg::sample_s   sample,
	input  wire logic                         soft_reset_req,
	// Results and readback
	output climate_alert_pkg::sample_s        result,
	output logic                              result_valid,
	output climate_alert_pkg::history_s       history,
	output logic [7:0]                        history_crc [4],
	output climate_alert_pkg::thresholds_s    thresholds,
	output logic [15:0]                       status,
	output climate_alert_pkg::mode_e          mode,
	output logic                              measure_enable,
	output logic                              link_active
);

	import climate_alert_pkg::*;

	localparam logic [15:0] EXIT_N = 16'(`EXIT_CYCLES);

	// -----------------------------------------------------------
	// State
	// -----------------------------------------------------------
	typedef struct packed {
		logic [1:0]   rst_sync;
		logic [1:0]   pin_sync;
		logic [2:0]   scl_sync;
		logic         started;
		mode_e        mode;
		logic [15:0]  exit_cnt;
		logic [31:0]  nvm_cnt;
		thresholds_s  thr;
		thresholds_s  nvm_thr;
		logic         nvm_poweron;
		logic [15:0]  offset;
		logic [15:0]  pend_offset;
		history_s     hist;
		logic         t_high;
		logic         t_low;
		logic         h_high;
		logic         h_low;
		logic [15:0]  status;
		logic         alert;
		logic         nack;
		logic         ack;
		sample_s      result;
		logic         result_valid;
		logic         link_active;
		logic         meas_en;
	} state_s;

	// Power-on values; memory copies start at the factory defaults
	localparam state_s RST_ST = '{
		pin_sync: 2'b11,
		scl_sync: 3'b111,
		mode:     MODE_SLEEP,
		thr:      {`THR_SET_HIGH_RST, `THR_CLR_HIGH_RST,
			`THR_SET_LOW_RST, `THR_CLR_LOW_RST},
		nvm_thr:  {`THR_SET_HIGH_RST, `THR_CLR_HIGH_RST,
			`THR_SET_LOW_RST, `THR_CLR_LOW_RST},
		hist:     {`HIST_MIN_T_RST, `HIST_MAX_T_RST,
			`HIST_MIN_H_RST, `HIST_MAX_H_RST},
		default:  '0
	};

	state_s st;
	state_s next_st;
	logic   rst_n;

	assign rst_n = st.rst_sync[1];

	// -----------------------------------------------------------
	// Checksums
	// -----------------------------------------------------------
	logic [7:0] cmd_crc;
	logic [15:0] hist_words [4];

	crc8_word u_cmd_crc (
		.word (cmd.data),
		.crc  (cmd_crc)
	);

	assign hist_words[0] = st.hist.min_t;
	assign hist_words[1] = st.hist.max_t;
	assign hist_words[2] = st.hist.min_h;
	assign hist_words[3] = st.hist.max_h;

	for (genvar g = 0; g < 4; g++) begin : g_hist_crc
		logic [7:0] c;
		crc8_word u_crc (
			.word (hist_words[g]),
			.crc  (c)
		);
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				history_crc[g] <= 8'h00;
			end else begin
				history_crc[g] <= c;
			end
		end
	end

	// -----------------------------------------------------------
	// Offset arithmetic, saturating at the code range
	// -----------------------------------------------------------
	function automatic logic [15:0] apply_ofs(
		input logic [15:0] raw,
		input logic [15:0] mag,
		input logic        add
	);
		logic [16:0] s;
		if (add) begin
			s = {1'b0, raw} + {1'b0, mag};
			apply_ofs = s[16] ? 16'hFFFF : s[15:0];
		end else begin
			s = {1'b0, raw} - {1'b0, mag};
			apply_ofs = s[16] ? 16'h0000 : s[15:0];
		end
	endfunction : apply_ofs

	// -----------------------------------------------------------
	// Next state
	// -----------------------------------------------------------
	logic [15:0] h_mag;
	logic [15:0] t_mag;
	logic [6:0]  h_cut;
	logic [8:0]  t_cut;
	logic        t_track;
	logic        h_track;
	logic        soft_rst;
	logic        leave_periodic;

	always_comb begin
		next_st = st;
		next_st.rst_sync = {st.rst_sync[0], 1'b1};
		next_st.pin_sync = {st.pin_sync[0], reset_pin_n};
		next_st.scl_sync = {st.scl_sync[1:0], scl};
		next_st.nack = 1'b0;
		next_st.ack = 1'b0;
		next_st.result_valid = 1'b0;
		leave_periodic = 1'b0;
		soft_rst = soft_reset_req
			|| (cmd_valid && cmd.cmd == CMD_SOFT_RESET);

		// Link activity on any edge of the sampled serial clock
		next_st.link_active = st.scl_sync[2] ^ st.scl_sync[1];

		// fields, humidity LSB at code bit 7, temperature LSB at code bit 6
		h_mag = {2'b00, st.offset[`OFS_H_MSB:`OFS_H_LSB], 7'b000_0000};
		t_mag = {3'b000, st.offset[`OFS_T_MSB:`OFS_T_LSB], 6'b00_0000};

		h_cut = sample.hum[15:9];
		t_cut = sample.temp[15:7];
		t_track = !(st.thr.set_low[`THR_T_MSB:`THR_T_LSB]
			> st.thr.set_high[`THR_T_MSB:`THR_T_LSB]);
		h_track = !(st.thr.set_low[`THR_H_MSB:`THR_H_LSB]
			> st.thr.set_high[`THR_H_MSB:`THR_H_LSB]);

		// Power-on start: mode from stored override
		if (!st.started) begin
			next_st.started = 1'b1;
			next_st.mode = st.nvm_poweron ? MODE_PERIODIC
				: MODE_SLEEP;
			next_st.thr = st.nvm_thr;
		end

		// Status clear first, so a sample in the same cycle still sets
		if (cmd_valid && st.mode != MODE_NVM_BUSY
			&& cmd.cmd == CMD_CLEAR_STATUS) begin
			next_st.t_high = 1'b0;
			next_st.t_low = 1'b0;
			next_st.h_high = 1'b0;
			next_st.h_low = 1'b0;
		end

		// Measurement results and history
		if (sample_valid && st.mode == MODE_PERIODIC) begin
			next_st.result.temp = apply_ofs(sample.temp, t_mag,
				st.offset[`OFS_T_SIGN]);
			// Compensation upstream sees raw temperature only
			next_st.result.hum = apply_ofs(sample.hum, h_mag,
				st.offset[`OFS_H_SIGN]);
			next_st.result_valid = 1'b1;
			if (sample.temp < st.hist.min_t) begin
				next_st.hist.min_t = sample.temp;
			end
			if (sample.temp > st.hist.max_t) begin
				next_st.hist.max_t = sample.temp;
			end
			if (sample.hum < st.hist.min_h) begin
				next_st.hist.min_h = sample.hum;
			end
			if (sample.hum > st.hist.max_h) begin
				next_st.hist.max_h = sample.hum;
			end

			// Hysteresis comparators
			if (t_track) begin
				if (t_cut > st.thr.set_high[`THR_T_MSB:`THR_T_LSB]) begin
					next_st.t_high = 1'b1;
				end else if (t_cut
					< st.thr.clr_high[`THR_T_MSB:`THR_T_LSB]) begin
					next_st.t_high = 1'b0;
				end
				if (t_cut < st.thr.set_low[`THR_T_MSB:`THR_T_LSB]) begin
					next_st.t_low = 1'b1;
				end else if (t_cut
					> st.thr.clr_low[`THR_T_MSB:`THR_T_LSB]) begin
					next_st.t_low = 1'b0;
				end
			end else begin
				next_st.t_high = 1'b0;
				next_st.t_low = 1'b0;
			end
			if (h_track) begin
				if (h_cut > st.thr.set_high[`THR_H_MSB:`THR_H_LSB]) begin
					next_st.h_high = 1'b1;
				end else if (h_cut
					< st.thr.clr_high[`THR_H_MSB:`THR_H_LSB]) begin
					next_st.h_high = 1'b0;
				end
				if (h_cut < st.thr.set_low[`THR_H_MSB:`THR_H_LSB]) begin
					next_st.h_low = 1'b1;
				end else if (h_cut
					> st.thr.clr_low[`THR_H_MSB:`THR_H_LSB]) begin
					next_st.h_low = 1'b0;
				end
			end else begin
				next_st.h_high = 1'b0;
				next_st.h_low = 1'b0;
			end
		end

		// Commands; refused while memory is being programmed, though a soft reset command still acts
		if (cmd_valid && st.mode != MODE_NVM_BUSY) begin
			case (cmd.cmd)
			CMD_START_PERIODIC: begin
				if (st.mode == MODE_SLEEP) begin
					next_st.mode = MODE_PERIODIC;
				end
				next_st.ack = 1'b1;
			end
			CMD_EXIT_PERIODIC: begin
				if (st.mode == MODE_PERIODIC) begin
					next_st.mode = MODE_EXITING;
					next_st.exit_cnt = EXIT_N;
					leave_periodic = 1'b1;
				end
				next_st.ack = 1'b1;
			end
			CMD_WRITE_SET_HIGH, CMD_WRITE_CLR_HIGH,
			CMD_WRITE_SET_LOW, CMD_WRITE_CLR_LOW: begin
				if (cmd.crc != cmd_crc) begin
					next_st.nack = 1'b1;
				end else begin
					next_st.ack = 1'b1;
					case (cmd.cmd)
					CMD_WRITE_SET_HIGH: next_st.thr.set_high = cmd.data;
					CMD_WRITE_CLR_HIGH: next_st.thr.clr_high = cmd.data;
					CMD_WRITE_SET_LOW:  next_st.thr.set_low = cmd.data;
					default:            next_st.thr.clr_low = cmd.data;
					endcase
				end
			end
			CMD_SAVE_THRESHOLDS: begin
				next_st.nvm_thr = st.thr;
				next_st.ack = 1'b1;
			end
			CMD_WRITE_OFFSET: begin
				if (cmd.crc != cmd_crc) begin
					next_st.nack = 1'b1;
				end else begin
					next_st.pend_offset = cmd.data;
					next_st.nvm_cnt = NVM_CYCLES;
					next_st.mode = MODE_NVM_BUSY;
					leave_periodic = st.mode == MODE_PERIODIC;
					next_st.ack = 1'b1;
				end
			end
			CMD_STORE_POWERON: begin
				if (cmd.crc != cmd_crc) begin
					next_st.nack = 1'b1;
				end else begin
					next_st.nvm_poweron = cmd.data[15:8] != 8'h00;
					next_st.ack = 1'b1;
				end
			end
			CMD_CLEAR_STATUS: begin
				next_st.ack = 1'b1;
			end
			default: begin
				next_st.ack = 1'b0;
			end
			endcase
		end else if (cmd_valid) begin
			next_st.nack = 1'b1;
		end

		// Abort and offset programming timers
		case (st.mode)
		MODE_EXITING: begin
			next_st.exit_cnt = st.exit_cnt - 16'h0001;
			if (st.exit_cnt <= 16'h0001) begin
				next_st.mode = MODE_SLEEP;
			end
		end
		MODE_NVM_BUSY: begin
			next_st.nvm_cnt = st.nvm_cnt - 32'h0000_0001;
			if (st.nvm_cnt <= 32'h0000_0001) begin
				next_st.offset = st.pend_offset;
				next_st.mode = MODE_SLEEP;
			end
		end
		default: begin
			next_st.exit_cnt = st.exit_cnt;
		end
		endcase

		// Soft or general-call reset: as a hardware reset, memory kept
		if (soft_rst) begin
			leave_periodic = 1'b1;
			next_st.started = 1'b0;
			next_st.thr = st.nvm_thr;
			next_st.t_high = 1'b0;
			next_st.t_low = 1'b0;
			next_st.h_high = 1'b0;
			next_st.h_low = 1'b0;
			next_st.mode = MODE_SLEEP;
		end

		// Reset pin held: alert off and status cleared
		if (!st.pin_sync[1]) begin
			next_st.t_high = 1'b0;
			next_st.t_low = 1'b0;
			next_st.h_high = 1'b0;
			next_st.h_low = 1'b0;
			next_st.started = 1'b0;
			next_st.mode = MODE_SLEEP;
			next_st.thr = st.nvm_thr;
		end

		// History defaults outside periodic mode, after every mode change
		if (leave_periodic || next_st.mode != MODE_PERIODIC) begin
			next_st.hist.min_t = `HIST_MIN_T_RST;
			next_st.hist.max_t = `HIST_MAX_T_RST;
			next_st.hist.min_h = `HIST_MIN_H_RST;
			next_st.hist.max_h = `HIST_MAX_H_RST;
		end

		next_st.status = 16'h0000;
		next_st.status[`STAT_H_HIGH_BIT] = next_st.h_high | next_st.t_high;
		next_st.status[`STAT_H_LOW_BIT] = next_st.h_low | next_st.t_low;
		next_st.status[`STAT_T_BIT] = next_st.t_high | next_st.t_low;
		next_st.status[`STAT_ALERT_BIT] = next_st.status[`STAT_H_HIGH_BIT]
			| next_st.status[`STAT_H_LOW_BIT];
		next_st.alert = next_st.status[`STAT_ALERT_BIT]
			| next_st.status[`STAT_H_HIGH_BIT]
			| next_st.status[`STAT_H_LOW_BIT]
			| next_st.status[`STAT_T_BIT];
		next_st.meas_en = next_st.mode == MODE_PERIODIC;

		// Internal reset still held: all but the synchroniser at rest
		if (!rst_n) begin
			next_st = RST_ST;
			next_st.rst_sync = {st.rst_sync[0], 1'b1};
		end
	end

	// -----------------------------------------------------------
	// Registers
	// -----------------------------------------------------------
	// Asynchronous assertion; release through the synchroniser field
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= RST_ST;
		end else begin
			st <= next_st;
		end
	end

	assign alert          = st.alert;
	assign cmd_nack       = st.nack;
	assign cmd_ack        = st.ack;
	assign result         = st.result;
	assign result_valid   = st.result_valid;
	assign history        = st.hist;
	assign thresholds     = st.thr;
	assign status         = st.status;
	assign mode           = st.mode;
	assign measure_enable = st.meas_en;
	assign link_active    = st.link_active;

endmodule : climate_alert_core

`default_nettype wire

/* File: climate_alert_params.svh */
/*
 * Constants of the climate sensor alert and history logic: defaults,
 * field positions and timing counts.
 * Assumes a 40 MHz core clock.
 */
`ifndef CLIMATE_ALERT_PARAMS_SVH
`define CLIMATE_ALERT_PARAMS_SVH

// ---------------------------------------------------------------
// Threshold defaults
// ---------------------------------------------------------------
`define THR_SET_HIGH_RST   16'hCD33
`define THR_CLR_HIGH_RST   16'hC92D
`define THR_SET_LOW_RST    16'h3466
`define THR_CLR_LOW_RST    16'h3869

// ---------------------------------------------------------------
// History defaults (codes for 130 C, -45 C, 100 %, 0 %)
// ---------------------------------------------------------------
`define HIST_MIN_T_RST     16'hFFFF
`define HIST_MAX_T_RST     16'h0000
`define HIST_MIN_H_RST     16'hFFFF
`define HIST_MAX_H_RST     16'h0000

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define THR_H_MSB          15
`define THR_H_LSB          9
`define THR_T_MSB          8
`define THR_T_LSB          0
`define OFS_H_SIGN         15
`define OFS_H_MSB          13
`define OFS_H_LSB          7
`define OFS_T_SIGN         14
`define OFS_T_MSB          12
`define OFS_T_LSB          6
`define STAT_ALERT_BIT     15
`define STAT_H_HIGH_BIT    11
`define STAT_H_LOW_BIT     10
`define STAT_T_BIT         4

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_HZ             40000000
`define EXIT_TIME_US       1000
`define EXIT_CYCLES        ((`EXIT_TIME_US * (`CLK_HZ / 1000000)))
`define NVM_PROG_TIME_US   77000
`define NVM_PROG_CYCLES    ((`NVM_PROG_TIME_US * (`CLK_HZ / 1000000)))

`endif

/* File: climate_alert_pkg.sv */
/*
 * Types shared by the climate sensor alert logic.
 * Assumes climate_alert_params.svh for the numbers.
 */
package climate_alert_pkg;

	typedef enum logic [3:0] {
		CMD_NONE,
		CMD_START_PERIODIC,
		CMD_EXIT_PERIODIC,
		CMD_SOFT_RESET,
		CMD_WRITE_SET_HIGH,
		CMD_WRITE_CLR_HIGH,
		CMD_WRITE_SET_LOW,
		CMD_WRITE_CLR_LOW,
		CMD_SAVE_THRESHOLDS,
		CMD_WRITE_OFFSET,
		CMD_STORE_POWERON,
		CMD_CLEAR_STATUS
	} cmd_e;

	typedef enum logic [1:0] {
		MODE_SLEEP,
		MODE_PERIODIC,
		MODE_EXITING,
		MODE_NVM_BUSY
	} mode_e;

	typedef struct packed {
		logic [15:0] set_high;
		logic [15:0] clr_high;
		logic [15:0] set_low;
		logic [15:0] clr_low;
	} thresholds_s;

	typedef struct packed {
		logic [15:0] min_t;
		logic [15:0] max_t;
		logic [15:0] min_h;
		logic [15:0] max_h;
	} history_s;

	typedef struct packed {
		cmd_e        cmd;
		logic [15:0] data;
		logic [7:0]  crc;
	} command_s;

	typedef struct packed {
		logic [15:0] temp;
		logic [15:0] hum;
	} sample_s;

endpackage : climate_alert_pkg

/* File: crc8_word.sv */
/*
 * Combinational CRC-8 (poly 0x31, init 0xFF) over one 16-bit word.
 * Assumes nothing of its surroundings; pure logic.
 */
`timescale 1ns/100ps
`default_nettype none

module crc8_word (
	// Word in
	input  wire logic [15:0] word,
	// Checksum out
	output logic      [7:0]  crc
);

	always_comb begin
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 15; i >= 0; i--) begin
			if (c[7] ^ word[i]) begin
				c = {c[6:0], 1'b0} ^ 8'h31;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		crc = c;
	end

endmodule : crc8_word

`default_nettype wire

/* File: climate_alert_checker.sv */
/* Port assertions for climate_alert_core.
   Assumes the bind at the foot of this file and the shared package. */
`timescale 1ns/100ps
`default_nettype none
module climate_alert_checker (
	// Clock and reset
	input wire logic                           clk,
	input wire logic                           arst_n,
	// Stimulus
	input wire logic                           cmd_valid,
	input wire climate_alert_pkg::command_s    cmd,
	input wire logic                           sample_valid,
	input wire climate_alert_pkg::sample_s     sample,
	// Responses
	input wire logic                           alert,
	input wire logic                           cmd_nack,
	input wire logic                           cmd_ack,
	input wire logic                           result_valid,
	input wire climate_alert_pkg::history_s    history,
	input wire climate_alert_pkg::thresholds_s thresholds,
	input wire logic [15:0]                    status,
	input wire climate_alert_pkg::mode_e       mode
);
	import climate_alert_pkg::*;
	logic [16:0] exit_cycles;
	// Cycles spent leaving periodic mode
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			exit_cycles <= '0;
		end else begin
			exit_cycles <= (mode == MODE_EXITING) ? exit_cycles + 1'b1 : '0;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_exit_taken;
		cmd_valid && cmd.cmd == CMD_EXIT_PERIODIC && mode == MODE_PERIODIC;
	endsequence
	sequence s_set_high_taken;
		cmd_valid && cmd.cmd == CMD_WRITE_SET_HIGH ##1 cmd_ack;
	endsequence
	property p_alert_or;
		alert == (status[15] | status[11] | status[10] | status[4]);
	endproperty
	a_alert_or: assert property (p_alert_or)
		else $error("alert not the OR of status bits");
	property p_busy_nack;
		cmd_valid && mode == MODE_NVM_BUSY |=> cmd_nack && !cmd_ack;
	endproperty
	a_busy_nack: assert property (p_busy_nack)
		else $error("command taken while busy");
	property p_exit;
		s_exit_taken |=> mode == MODE_EXITING
			&& history == 64'hFFFF_0000_FFFF_0000;
	endproperty
	a_exit: assert property (p_exit)
		else $error("exit did not restore history");
	property p_hist_idle;
		mode != MODE_PERIODIC |-> history == 64'hFFFF_0000_FFFF_0000;
	endproperty
	a_hist_idle: assert property (p_hist_idle)
		else $error("history not default outside periodic");
	property p_result;
		sample_valid |=> result_valid == ($past(mode) == MODE_PERIODIC);
	endproperty
	a_result: assert property (p_result)
		else $error("result strobe wrong");
	property p_extremes;
		sample_valid && mode == MODE_PERIODIC |=> mode != MODE_PERIODIC
			|| (history.max_t >= $past(sample.temp)
			&& history.min_h <= $past(sample.hum));
	endproperty
	a_extremes: assert property (p_extremes)
		else $error("history extreme not updated");
	property p_exit_len;
		exit_cycles <= 17'h0_9C40;
	endproperty
	a_exit_len: assert property (p_exit_len)
		else $error("exit took too long");
	property p_set_high;
		s_set_high_taken |-> thresholds.set_high == $past(cmd.data);
	endproperty
	a_set_high: assert property (p_set_high)
		else $error("threshold write not applied");
endmodule : climate_alert_checker
bind climate_alert_core climate_alert_checker CHK (.clk, .arst_n,
	.cmd_valid, .cmd, .sample_valid, .sample, .alert, .cmd_nack, .cmd_ack,
	.result_valid, .history, .thresholds, .status, .mode);
`default_nettype wire

/* File: serial_host_model.sv */
/* Behavioural serial bus controller in front of the sensor core.
   Assumes the bench calls send; scl idles high between frames. */
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
	// Clock
	input  wire logic                        clk,
	// Decoded command port
	output logic                             cmd_valid,
	output climate_alert_pkg::command_s      cmd,
	// Serial clock pin
	output logic                             scl
);
	import climate_alert_pkg::*;
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
		scl = 1'b1;
	end
	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
		end
		return c;
	endfunction : crc8
	// One frame: nine serial clocks, then the decoded command strobe
	task automatic send(input cmd_e op, input logic [15:0] w, input logic bad);
		repeat (9) begin
			#100 scl = 1'b0;
			#100 scl = 1'b1;
		end
		@(posedge clk);
		#2;
		cmd_valid = 1'b1;
		cmd = '{op, w, crc8(w) ^ {7'h00, bad}};
		@(posedge clk);
		#2;
		cmd_valid = 1'b0;
		// Stale fields must not look valid
		cmd = command_s'(~cmd);
	endtask : send
endmodule : serial_host_model
`default_nettype wire

/* File: climate_sensor_alert_history_test.sv */
/* Self-checking bench for climate_alert_core.
   Assumes serial_host_model drives the command port. */
`timescale 1ns/100ps
`default_nettype none
module climate_sensor_alert_history_test;
	import climate_alert_pkg::*;
	localparam int          NVM = 200;
	localparam logic [63:0] HDEF = 64'hFFFF_0000_FFFF_0000;
	logic          clk = 1'b0, arst_n = 1'b0, reset_pin_n = 1'b1;
	logic          sample_valid = 1'b0, soft_reset_req = 1'b0;
	sample_s       sample = '0, result;
	logic          cmd_valid, scl, alert, cmd_nack, cmd_ack, result_valid;
	logic          measure_enable, link_active;
	command_s      cmd;
	history_s      history;
	thresholds_s   thresholds;
	logic [15:0]   status;
	mode_e         mode;
	logic [7:0]    history_crc [4];
	int            miscompares = 0, check_count = 0, cycles = 0;
	int            link_edges = 0;
	always #12.5 clk = ~clk;
	serial_host_model HOST (.clk, .cmd_valid, .cmd, .scl);
	climate_alert_core #(.NVM_CYCLES(NVM)) DUT (.clk, .arst_n, .reset_pin_n,
		.scl, .alert, .cmd_valid, .cmd, .cmd_nack, .cmd_ack, .sample_valid,
		.sample, .soft_reset_req, .result, .result_valid, .history,
		.history_crc, .thresholds, .status, .mode, .measure_enable,
		.link_active);
	// Link activity pulses, counted where they are settled
	always @(negedge clk) begin
		if (link_active === 1'b1) begin
			link_edges++;
		end
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic print_verdict;
		if (miscompares == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step
	task automatic go(input cmd_e op, input logic [15:0] w, input logic bad);
		HOST.send(op, w, bad);
	endtask : go
	task automatic smp(input logic [15:0] t, input logic [15:0] h);
		step(1);
		sample_valid = 1'b1;
		sample = '{t, h};
		step(1);
		sample_valid = 1'b0;
		sample = ~sample;
	endtask : smp
	task automatic wait_mode(input mode_e m, input int lim);
		for (int n = 0; mode !== m && n < lim; n++) step(1);
		check(mode, m);
	endtask : wait_mode
	task automatic t_defaults;
		check(thresholds, 64'hCD33_C92D_3466_3869);
		check(history, HDEF);
		check({mode, alert}, {MODE_SLEEP, 1'b0});
		check(history_crc[1], 8'h81);
	endtask : t_defaults
	task automatic t_thresholds;
		go(CMD_WRITE_SET_HIGH, 16'hE741, 1'b0);
		check({cmd_ack, thresholds.set_high}, 17'h1_E741);
		go(CMD_WRITE_CLR_HIGH, 16'h1234, 1'b1);
		check({cmd_nack, thresholds.clr_high}, 17'h1_C92D);
		go(CMD_SOFT_RESET, 16'h0000, 1'b0);
		step(4);
		check(thresholds.set_high, 16'hCD33);
		check(link_edges, 54);
	endtask : t_thresholds
	task automatic t_alerts;
		go(CMD_START_PERIODIC, 16'h0000, 1'b0);
		check(mode, MODE_PERIODIC);
		smp(16'h9000, 16'h7000);
		check(result, 32'h9000_7000);
		smp(16'h8000, 16'h7800);
		check(history, 64'h8000_9000_7000_7800);
		smp(16'hFFFF, 16'hFFFF);
		check({alert, status[15], status[11]}, 3'b111);
		smp(16'h9800, 16'hCA00);
		check(alert, 1'b1);
		smp(16'h8000, 16'h8000);
		check(alert, 1'b0);
		smp(16'h0000, 16'h0000);
		check({alert, status[10]}, 2'b11);
		go(CMD_CLEAR_STATUS, 16'h0000, 1'b0);
		check(alert, 1'b0);
		smp(16'h0000, 16'h0000);
		reset_pin_n = 1'b0;
		step(4);
		check({alert, status, mode}, {17'h0_0000, MODE_SLEEP});
		reset_pin_n = 1'b1;
		step(4);
	endtask : t_alerts
	task automatic t_disable_exit;
		go(CMD_WRITE_SET_LOW, 16'h35FF, 1'b0);
		go(CMD_START_PERIODIC, 16'h0000, 1'b0);
		smp(16'hFFFF, 16'h8000);
		check(alert, 1'b0);
		go(CMD_EXIT_PERIODIC, 16'h0000, 1'b0);
		check({mode, measure_enable}, {MODE_EXITING, 1'b0});
		check(history, HDEF);
		smp(16'h1234, 16'h1234);
		check(result_valid, 1'b0);
		wait_mode(MODE_SLEEP, 40100);
	endtask : t_disable_exit
	task automatic t_save_offset;
		go(CMD_WRITE_SET_HIGH, 16'hE741, 1'b0);
		go(CMD_SAVE_THRESHOLDS, 16'h0000, 1'b0);
		check(cmd_ack, 1'b1);
		wait_mode(MODE_SLEEP, NVM + 10);
		go(CMD_SOFT_RESET, 16'h0000, 1'b0);
		step(4);
		check(thresholds.set_high, 16'hE741);
		go(CMD_WRITE_OFFSET, 16'h4080, 1'b0);
		check(mode, MODE_NVM_BUSY);
		go(CMD_START_PERIODIC, 16'h0000, 1'b0);
		check(cmd_nack, 1'b1);
		wait_mode(MODE_SLEEP, NVM);
	endtask : t_save_offset
	task automatic t_override;
		go(CMD_STORE_POWERON, 16'h0300, 1'b0);
		wait_mode(MODE_SLEEP, NVM + 10);
		soft_reset_req = 1'b1;
		step(1);
		soft_reset_req = 1'b0;
		wait_mode(MODE_PERIODIC, 10);
		smp(16'h4321, 16'h5678);
		check(result, 32'h43A1_55F8);
	endtask : t_override
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		step(5);
		arst_n = 1'b1;
		step(5);
		t_defaults();
		t_thresholds();
		t_alerts();
		t_disable_exit();
		t_save_offset();
		t_override();
		print_verdict();
	end
endmodule : climate_sensor_alert_history_test
`default_nettype wire
